// ===== core/cmpe_consts.svh
// Constants for the comparator edge control block: register addresses,
// field positions and reset values.
// Assumes it is included by its bare name wherever the values are needed.
//
// Overview of operation
// - The comparator runs only while the enable bit is one, and writing zero turns it off.
// - The read-only result bit reads one when the plus input is above the minus input, while the comparator is on.
// - A low-to-high change of the comparator output sets the rising-edge flag.
// - A high-to-low change of the comparator output sets the falling-edge flag.
// - Both edge flags stay set until software writes zero, and hardware never clears them.
// - An interrupt is requested while the rising-edge flag and its enable are both one.
// - An interrupt is requested while the falling-edge flag and its enable are both one.
// - Control bits 3 to 2 choose positive hysteresis of none, 5 mV, 10 mV or 20 mV.
// - Control bits 1 to 0 choose negative hysteresis of none, 5 mV, 10 mV or 20 mV.
// - While the comparator is off, every comparator output to a pin is held low.
// - A latched output is made by registering the decision on the system clock.
// - A raw unregistered output stays valid while the system clock is stopped.
// - Two four-bit input selects pick one of eight pins each, and a set top bit picks none.
// - A two-bit response speed field picks mode 0 fastest to mode 3 slowest, reset to mode 2.
// - The rise and fall interrupt enables sit at mode bits 5 and 4 and reset to zero.

`ifndef CMPE_CONSTS_SVH
`define CMPE_CONSTS_SVH

// Register addresses on the special function register bus.
`define CMPE_ADDR_CTRL 8'h9b
`define CMPE_ADDR_MODE 8'h9d
`define CMPE_ADDR_MUX 8'h9f

// Reset values.
`define CMPE_RST_CTRL 8'h00
`define CMPE_RST_MODE 8'h02
`define CMPE_RST_MUX 8'hff
`define CMPE_RST_SPEED 2'h2
`define CMPE_RST_SEL 4'hf

// Control register fields.
`define CMPE_CTRL_ON_BIT 7
`define CMPE_CTRL_RESULT_BIT 6
`define CMPE_CTRL_RISE_BIT 5
`define CMPE_CTRL_FALL_BIT 4
`define CMPE_CTRL_HYP_HI 3
`define CMPE_CTRL_HYP_LO 2
`define CMPE_CTRL_HYN_HI 1
`define CMPE_CTRL_HYN_LO 0

// Mode register fields.
`define CMPE_MODE_RISE_IE_BIT 5
`define CMPE_MODE_FALL_IE_BIT 4
`define CMPE_MODE_SPEED_HI 1
`define CMPE_MODE_SPEED_LO 0

// Input select register fields; the top bit of each select means none.
`define CMPE_MUX_NEG_HI 7
`define CMPE_MUX_NEG_LO 4
`define CMPE_MUX_POS_HI 3
`define CMPE_MUX_POS_LO 0
`define CMPE_SEL_NONE_BIT 3

// Answer to a read of an address that holds no register here.
`define CMPE_UNMAPPED_DATA 8'h00

`endif

// ===== core/cmpe_pkg.sv
// Types for the comparator edge control block.
// Assumes the constants header sits beside it on the include path.

`include "cmpe_consts.svh"

package cmpe_pkg;

   // One access on the special function register bus.
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cmpe_sfr_req_t;

   // Hysteresis amounts, in the encoding of the two-bit fields.
   typedef enum logic [1:0] {
      CMPE_HYST_OFF,
      CMPE_HYST_5MV,
      CMPE_HYST_10MV,
      CMPE_HYST_20MV
   } cmpe_hyst_t;

   // Settings driven to the analog comparator.
   typedef struct packed {
      logic comparator_on;
      cmpe_hyst_t pos_hysteresis_sel;
      cmpe_hyst_t neg_hysteresis_sel;
      logic [1:0] response_speed_sel;
      logic [3:0] plus_input_select;
      logic [3:0] minus_input_select;
      logic plus_input_none;
      logic minus_input_none;
   } cmpe_analog_cfg_t;

   // Entire state of the block.
   typedef struct packed {
      logic comparator_on;
      cmpe_hyst_t pos_hysteresis_sel;
      cmpe_hyst_t neg_hysteresis_sel;
      logic rise_event_flag;
      logic fall_event_flag;
      logic rise_irq_enable;
      logic fall_irq_enable;
      logic [1:0] response_speed_sel;
      logic [3:0] plus_input_select;
      logic [3:0] minus_input_select;
      logic sync_first;
      logic sync_second;
      logic sync_third;
      logic stable_compare;
      logic decided_compare;
      logic [7:0] rdata;
   } cmpe_state_t;

endpackage

// ===== core/cmpe_core.sv
// Digital control and edge event logic of the on-chip voltage comparator.
// Assumes the analog comparator drives raw_compare_in asynchronously and
// that the processor reaches the three registers over its special function
// register bus, with a read answered one clock after the strobe.

`timescale 1ns/10ps

module cmpe_core (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire cmpe_pkg::cmpe_sfr_req_t sfr_req_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic raw_compare_in,
   output cmpe_pkg::cmpe_analog_cfg_t analog_cfg_out,
   output logic raw_compare_out,
   output logic latched_compare_out,
   output logic irq_out
);

   import cmpe_pkg::*;

   ////////////////////////////////////////////////////////////////////////

   localparam cmpe_state_t STATE_RESET = '{
      comparator_on: 1'b0,
      pos_hysteresis_sel: CMPE_HYST_OFF,
      neg_hysteresis_sel: CMPE_HYST_OFF,
      rise_event_flag: 1'b0,
      fall_event_flag: 1'b0,
      rise_irq_enable: 1'b0,
      fall_irq_enable: 1'b0,
      response_speed_sel: `CMPE_RST_SPEED,
      plus_input_select: `CMPE_RST_SEL,
      minus_input_select: `CMPE_RST_SEL,
      sync_first: 1'b0,
      sync_second: 1'b0,
      sync_third: 1'b0,
      stable_compare: 1'b0,
      decided_compare: 1'b0,
      rdata: 8'h00
   };

   cmpe_state_t state_reg;
   cmpe_state_t state_next;

   logic decision;
   logic rise_seen;
   logic fall_seen;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_mux;
   logic [7:0] ctrl_view;
   logic [7:0] mode_view;
   logic [7:0] mux_view;
   logic [7:0] read_data;

   // Write data split into the fields of the three registers, then next-state values.
   logic wd_on;
   logic wd_rise_flag;
   logic wd_fall_flag;
   cmpe_hyst_t wd_pos_hyst;
   cmpe_hyst_t wd_neg_hyst;
   logic wd_rise_ie;
   logic wd_fall_ie;
   logic [1:0] wd_speed;
   logic [3:0] wd_minus_sel;
   logic [3:0] wd_plus_sel;
   logic sync_first_next;
   logic sync_second_next;
   logic sync_third_next;
   logic stable_next;
   logic rise_flag_next;
   logic fall_flag_next;
   logic [7:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////
   // Register views as software reads them.

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`CMPE_CTRL_ON_BIT] = state_reg.comparator_on;
      ctrl_view[`CMPE_CTRL_RESULT_BIT] = state_reg.decided_compare;
      ctrl_view[`CMPE_CTRL_RISE_BIT] = state_reg.rise_event_flag;
      ctrl_view[`CMPE_CTRL_FALL_BIT] = state_reg.fall_event_flag;
      ctrl_view[`CMPE_CTRL_HYP_HI:`CMPE_CTRL_HYP_LO] =
         state_reg.pos_hysteresis_sel;
      ctrl_view[`CMPE_CTRL_HYN_HI:`CMPE_CTRL_HYN_LO] =
         state_reg.neg_hysteresis_sel;
   end

   always_comb begin
      mode_view = 8'h00;
      mode_view[`CMPE_MODE_RISE_IE_BIT] = state_reg.rise_irq_enable;
      mode_view[`CMPE_MODE_FALL_IE_BIT] = state_reg.fall_irq_enable;
      mode_view[`CMPE_MODE_SPEED_HI:`CMPE_MODE_SPEED_LO] =
         state_reg.response_speed_sel;
   end

   always_comb begin
      mux_view = 8'h00;
      mux_view[`CMPE_MUX_NEG_HI:`CMPE_MUX_NEG_LO] =
         state_reg.minus_input_select;
      mux_view[`CMPE_MUX_POS_HI:`CMPE_MUX_POS_LO] =
         state_reg.plus_input_select;
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode and read multiplexer.

   assign wr_ctrl = sfr_req_in.wr && (sfr_req_in.addr == `CMPE_ADDR_CTRL);
   assign wr_mode = sfr_req_in.wr && (sfr_req_in.addr == `CMPE_ADDR_MODE);
   assign wr_mux = sfr_req_in.wr && (sfr_req_in.addr == `CMPE_ADDR_MUX);

   always_comb begin
      case (sfr_req_in.addr)
         `CMPE_ADDR_CTRL: begin
            read_data = ctrl_view;
         end
         `CMPE_ADDR_MODE: begin
            read_data = mode_view;
         end
         `CMPE_ADDR_MUX: begin
            read_data = mux_view;
         end
         default: begin
            read_data = `CMPE_UNMAPPED_DATA;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Write data fields.

   assign wd_on = sfr_req_in.wdata[`CMPE_CTRL_ON_BIT];
   assign wd_rise_flag = sfr_req_in.wdata[`CMPE_CTRL_RISE_BIT];
   assign wd_fall_flag = sfr_req_in.wdata[`CMPE_CTRL_FALL_BIT];
   assign wd_pos_hyst = cmpe_hyst_t'(
      sfr_req_in.wdata[`CMPE_CTRL_HYP_HI:`CMPE_CTRL_HYP_LO]);
   assign wd_neg_hyst = cmpe_hyst_t'(
      sfr_req_in.wdata[`CMPE_CTRL_HYN_HI:`CMPE_CTRL_HYN_LO]);
   assign wd_rise_ie = sfr_req_in.wdata[`CMPE_MODE_RISE_IE_BIT];
   assign wd_fall_ie = sfr_req_in.wdata[`CMPE_MODE_FALL_IE_BIT];
   assign wd_speed =
      sfr_req_in.wdata[`CMPE_MODE_SPEED_HI:`CMPE_MODE_SPEED_LO];
   assign wd_minus_sel =
      sfr_req_in.wdata[`CMPE_MUX_NEG_HI:`CMPE_MUX_NEG_LO];
   assign wd_plus_sel =
      sfr_req_in.wdata[`CMPE_MUX_POS_HI:`CMPE_MUX_POS_LO];

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser and decision.

   // three-stage input synchroniser
   // A change counts only once the second and third stages agree, which
   // drops a one-cycle glitch near the switching threshold.
   always_comb begin
      sync_first_next = raw_compare_in;
      sync_second_next = state_reg.sync_first;
      sync_third_next = state_reg.sync_second;
      stable_next = state_reg.stable_compare;
      if (state_reg.sync_second == state_reg.sync_third) begin
         stable_next = state_reg.sync_third;
      end
   end

   assign decision = state_reg.comparator_on & state_reg.stable_compare;

   assign rise_seen = decision & ~state_reg.decided_compare;
   assign fall_seen = ~decision & state_reg.decided_compare;

   ////////////////////////////////////////////////////////////////////////
   // Edge event flags.

   // flags hold until software writes
   // A hardware edge beats a clearing write in the same cycle, so an event
   // that lands on the clear is never lost; software sees it next read.
   always_comb begin
      rise_flag_next = state_reg.rise_event_flag;
      fall_flag_next = state_reg.fall_event_flag;
      if (wr_ctrl) begin
         rise_flag_next = wd_rise_flag;
         fall_flag_next = wd_fall_flag;
      end
      if (rise_seen) begin
         rise_flag_next = 1'b1;
      end
      if (fall_seen) begin
         fall_flag_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data capture.

   // Read data is captured at the strobe and held until the next read,
   // so a slow bus master may sample it late.
   always_comb begin
      rdata_next = state_reg.rdata;
      if (sfr_req_in.rd) begin
         rdata_next = read_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      state_next = state_reg;
      // Everything, the synchroniser included, holds while ce_in is low.
      if (ce_in) begin
         state_next.sync_first = sync_first_next;
         state_next.sync_second = sync_second_next;
         state_next.sync_third = sync_third_next;
         state_next.stable_compare = stable_next;
         state_next.decided_compare = decision;
         state_next.rise_event_flag = rise_flag_next;
         state_next.fall_event_flag = fall_flag_next;

         if (wr_ctrl) begin
            state_next.comparator_on = wd_on;
            state_next.pos_hysteresis_sel = wd_pos_hyst;
            state_next.neg_hysteresis_sel = wd_neg_hyst;
         end

         if (wr_mode) begin
            state_next.rise_irq_enable = wd_rise_ie;
            state_next.fall_irq_enable = wd_fall_ie;
            state_next.response_speed_sel = wd_speed;
         end

         if (wr_mux) begin
            state_next.minus_input_select = wd_minus_sel;
            state_next.plus_input_select = wd_plus_sel;
         end

         state_next.rdata = rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign sfr_rdata_out = state_reg.rdata;

   // The raw output bypasses the synchroniser on purpose, so it may
   // chatter while the inputs sit at the threshold; a pin that needs a
   // clean level should take the latched output instead.
   // raw output needs no clock
   assign raw_compare_out = state_reg.comparator_on & raw_compare_in;

   assign latched_compare_out =
      state_reg.comparator_on & state_reg.decided_compare;

   // The request is a level that stays up until software clears the flag
   // or its enable, so a slow interrupt controller cannot lose an event.
   // rising and falling interrupt request
   assign irq_out =
      (state_reg.rise_event_flag & state_reg.rise_irq_enable) |
      (state_reg.fall_event_flag & state_reg.fall_irq_enable);

   always_comb begin
      analog_cfg_out.comparator_on = state_reg.comparator_on;
      analog_cfg_out.pos_hysteresis_sel = state_reg.pos_hysteresis_sel;
      analog_cfg_out.neg_hysteresis_sel = state_reg.neg_hysteresis_sel;
      analog_cfg_out.response_speed_sel = state_reg.response_speed_sel;
      analog_cfg_out.plus_input_select = state_reg.plus_input_select;
      analog_cfg_out.minus_input_select = state_reg.minus_input_select;
      analog_cfg_out.plus_input_none =
         state_reg.plus_input_select[`CMPE_SEL_NONE_BIT];
      analog_cfg_out.minus_input_none =
         state_reg.minus_input_select[`CMPE_SEL_NONE_BIT];
   end

endmodule

// ===== verif/cmpe_core_asserts.sv
// Concurrent checks on the ports of the comparator edge control block.
// Assumes it is bound to cmpe_core and sees nothing but its ports.
`timescale 1ns/10ps
module cmpe_chk (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire cmpe_pkg::cmpe_sfr_req_t sfr_req_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic raw_compare_in,
   input wire cmpe_pkg::cmpe_analog_cfg_t analog_cfg_out,
   input wire logic raw_compare_out,
   input wire logic latched_compare_out,
   input wire logic irq_out
);
   import cmpe_pkg::*;
   logic on;
   logic wr_ctrl;
   assign on = analog_cfg_out.comparator_on;
   assign wr_ctrl = ce_in && sfr_req_in.wr && sfr_req_in.addr == 8'h9b;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////
   raw_gate_a: assert property (
      raw_compare_out == (on & raw_compare_in))
      else $error("raw output not gated by enable");
   off_low_a: assert property (
      !on |-> !latched_compare_out && !raw_compare_out)
      else $error("output high while comparator off");
   en_write_a: assert property (
      wr_ctrl |=> on == $past(sfr_req_in.wdata[7]))
      else $error("enable write not applied");
   hyst_write_a: assert property (
      wr_ctrl |=> {analog_cfg_out.pos_hysteresis_sel,
      analog_cfg_out.neg_hysteresis_sel} == $past(sfr_req_in.wdata[3:0]))
      else $error("hysteresis write not applied");
   speed_write_a: assert property (
      ce_in && sfr_req_in.wr && sfr_req_in.addr == 8'h9d |=>
      analog_cfg_out.response_speed_sel == $past(sfr_req_in.wdata[1:0]))
      else $error("speed write not applied");
   mux_write_a: assert property (
      ce_in && sfr_req_in.wr && sfr_req_in.addr == 8'h9f |=>
      {analog_cfg_out.minus_input_select, analog_cfg_out.plus_input_select}
      == $past(sfr_req_in.wdata))
      else $error("input select write not applied");
   rdata_hold_a: assert property (
      !(ce_in && sfr_req_in.rd) |=> $stable(sfr_rdata_out))
      else $error("read data changed without a read");
   irq_clear_a: assert property (
      $fell(irq_out) |-> $past(sfr_req_in.wr) && $past(ce_in))
      else $error("interrupt dropped without a write");
   latch_rise_a: assert property (
      (ce_in && on && $rose(raw_compare_in)) ##1
      (ce_in && on && raw_compare_in) [*5] |-> latched_compare_out)
      else $error("latched output late after rise");
   sel_none_a: assert property (
      analog_cfg_out.plus_input_none == analog_cfg_out.plus_input_select[3]
      && analog_cfg_out.minus_input_none ==
      analog_cfg_out.minus_input_select[3])
      else $error("input none flag wrong");
   cover property ($rose(irq_out));
   cover property ($rose(latched_compare_out));
   cover property (wr_ctrl && sfr_req_in.wdata[7]);
endmodule
bind cmpe_core cmpe_chk cmpe_chk_i (.clk_in(clk_in), .nrst_in(nrst_in),
   .ce_in(ce_in), .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
   .raw_compare_in(raw_compare_in), .analog_cfg_out(analog_cfg_out),
   .raw_compare_out(raw_compare_out),
   .latched_compare_out(latched_compare_out), .irq_out(irq_out));

// ===== verif/tb_cmpe_core.sv
// Self-checking bench for the comparator edge control block.
// Assumes the design and its bound checker are compiled before it.
`timescale 1ns/10ps
module tb_cmpe_core;
   import cmpe_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] r;
   } cmpe_row_t;
   logic clk_in = 0;
   logic nrst_in = 0;
   logic ce_in = 1;
   logic raw_compare_in = 0;
   cmpe_sfr_req_t sfr_req_in = '0;
   logic [7:0] sfr_rdata_out;
   cmpe_analog_cfg_t analog_cfg_out;
   logic raw_compare_out, latched_compare_out, irq_out;
   int mismatches = 0;
   int n_tests = 0;
   cmpe_row_t rows [12] = '{'{8'h9b, 8'h0f, 8'h0f}, '{8'h9b, 8'h45, 8'h05},
      '{8'h9b, 8'h0a, 8'h0a}, '{8'h9b, 8'h30, 8'h30}, '{8'h9b, 8'h00, 8'h00},
      '{8'h9d, 8'hff, 8'h33}, '{8'h9d, 8'h01, 8'h01}, '{8'h9d, 8'h00, 8'h00},
      '{8'h9d, 8'h03, 8'h03}, '{8'h9f, 8'h70, 8'h70}, '{8'h9f, 8'h88, 8'h88},
      '{8'h9c, 8'h55, 8'h00}};
   cmpe_core cmpe_core_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
      .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
      .raw_compare_in(raw_compare_in), .analog_cfg_out(analog_cfg_out),
      .raw_compare_out(raw_compare_out),
      .latched_compare_out(latched_compare_out), .irq_out(irq_out));
   always #50 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string n, input logic [7:0] e,
         input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   // Requests change at the falling edge and hold over one rising edge;
   // the strobe then stays low over the next rising edge, so two calls
   // in a row never lower and raise it in one time step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req_in = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk_in);
      sfr_req_in = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
      @(negedge clk_in);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      sfr_req_in = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk_in);
      sfr_req_in = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
      @(negedge clk_in);
      chk8("register read", e, sfr_rdata_out);
   endtask
   task automatic settle;
      repeat (5) @(negedge clk_in);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2000) @(posedge clk_in);
      mismatches++;
      final_report;
   end
   initial begin
      repeat (12) @(negedge clk_in);
      nrst_in = 1;
      rdchk(8'h9b, 8'h00);
      rdchk(8'h9d, 8'h02);
      rdchk(8'h9f, 8'hff);
      chk1("plus none", 1'b1, analog_cfg_out.plus_input_none);
      $display("reset values done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].r);
      end
      $display("register table done");
      wr(8'h9d, 8'h30);
      wr(8'h9b, 8'h80);
      settle;
      wr(8'h9b, 8'h80);
      chk1("irq idle", 1'b0, irq_out);
      raw_compare_in = 1;
      settle;
      rdchk(8'h9b, 8'he0);
      chk1("irq rise", 1'b1, irq_out);
      chk1("latched", 1'b1, latched_compare_out);
      chk1("raw out", 1'b1, raw_compare_out);
      wr(8'h9b, 8'h80);
      rdchk(8'h9b, 8'hc0);
      raw_compare_in = 0;
      settle;
      rdchk(8'h9b, 8'h90);
      chk1("irq fall", 1'b1, irq_out);
      wr(8'h9d, 8'h00);
      raw_compare_in = 1;
      settle;
      rdchk(8'h9b, 8'hf0);
      chk1("irq masked", 1'b0, irq_out);
      $display("edge events done");
      wr(8'h9b, 8'h00);
      settle;
      chk1("raw off", 1'b0, raw_compare_out);
      chk1("latched off", 1'b0, latched_compare_out);
      rdchk(8'h9b, 8'h10);
      ce_in = 0;
      wr(8'h9f, 8'h00);
      ce_in = 1;
      rdchk(8'h9f, 8'h88);
      nrst_in = 0;
      @(negedge clk_in);
      nrst_in = 1;
      rdchk(8'h9b, 8'h00);
      rdchk(8'h9d, 8'h02);
      $display("disable and reset done");
      final_report;
   end
endmodule
